// ### inc/sac_pkg.sv
// Constants, state type and helper for the serial SAR conversion port.
// Assumes a 50 MHz system clock; the serial clock is made by the host.
// Functional notes
// RULE_01: Each falling edge of chip_select_n starts a new conversion. The code ignores the edge while shutdown_level_input is low.
// RULE_02: serial_out is not driven while chip_select_n is high.
// RULE_03: serial_out changes level only after a serial_clock falling edge. The code also raises it at end of conversion with no edge.
// RULE_04: A low shutdown_level_input puts the device into shutdown.
// RULE_05: A high or floating shutdown_level_input keeps the device operating.
// RULE_06: High selects the internal reference, floating selects an external one.
// RULE_07: The result is a high end-of-conversion bit then 12 bits, MSB first.
// RULE_08: Sample-hold stops tracking when chip_select_n falls.
// RULE_09: Sample-hold returns to tracking when the conversion completes.
// RULE_10: The host leaves at least 1.5 us of acquisition before the next start.
// RULE_11: The host runs serial_clock no faster than 2.1 MHz.
// RULE_12: A whole conversion cycle, acquisition included, fits in 9 us.
// RULE_13: On the start edge the input is held and serial_out is driven low.
// RULE_14: The host keeps serial_clock low until the conversion has ended.
// RULE_15: serial_out goes high at end of conversion; 13 falling edges read it.
// RULE_16: Edges after the last result bit shift out zeros and change nothing.
// RULE_17: The shutdown input decodes low, high and floating into three modes.
package sac_pkg;
  localparam int SAC_BITS = 12;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CONV_NS = 7500;
  localparam int T_CYCLE_NS = 9000;
  localparam int CONV_CYCLES = T_CONV_NS / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_ZERO = 5'h00;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam logic [4:0] STEP_LAST = 5'(CONV_CYCLES / SAC_BITS - 1);
  localparam logic [3:0] BIT_MSB = 4'(SAC_BITS - 1);
  localparam logic [3:0] BIT_LSB = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_EOC = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_MSB = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'hC;
  localparam logic [3:0] CNT_SAT = 4'hD;
  localparam logic [3:0] PIN_RST = 4'h8;
  localparam int FIFO_DEPTH = 16;

  typedef enum {ST_SHUT, ST_IDLE, ST_CONV, ST_PUSH, ST_LOAD, ST_OUT} sac_state_t;

  function automatic logic [3:0] sac_gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : sac_gray2bin
endpackage : sac_pkg

// ### rtl/sac_sync.sv
// Two-stage level synchroniser for signals entering the system clock domain.
// Assumes multi-bit use only for gray-coded or independent bits.
`timescale 1ns/10ps
module sac_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk, // Destination clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic [W-1:0] i_d, // Asynchronous input
  output logic [W-1:0] o_q // Synchronised output
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= RST;
      o_q <= RST;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule : sac_sync

// ### rtl/sac_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; storage has no reset.
`timescale 1ns/10ps
module sac_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Not full
  input wire logic [W-1:0] i_wdata, // Write data
  output logic o_rvalid, // Not empty
  input wire logic i_rready, // Reader takes head
  output logic [W-1:0] o_rdata // Head entry
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign o_wready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign o_rvalid = (wr_q != rd_q);
  assign push = i_wvalid && o_wready;
  assign pop = i_rready && o_rvalid;
  assign o_rdata = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_wdata;
    end
  end
endmodule : sac_fifo

// ### rtl/sac_conv_port.sv
// Conversion control and serial read-out of a 12-bit SAR converter.
// Assumes an analog core with DAC, comparator and sample-hold switch,
// and a host that owns chip select and the serial clock.
`timescale 1ns/10ps
module sac_conv_port (
  input wire logic i_clk_sys, // 50 MHz conversion clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_sclk, // Serial clock from host
  input wire logic i_cs_n, // Chip select from host, active low
  input wire logic i_shutdown_level_input_above, // Shutdown input seen high
  input wire logic i_shutdown_level_input_below, // Shutdown input seen low
  input wire logic i_cmp, // Comparator: input at or above trial code
  output logic o_dout, // Serial data out
  output logic o_dout_oe, // Serial data drive enable
  output logic o_track, // Sample-hold tracks when high
  output logic [sac_pkg::SAC_BITS-1:0] o_dac_code, // Trial code to DAC
  output logic o_shutdown, // Analog core powered down
  output logic o_ref_int_en // Internal reference enabled
);
  import sac_pkg::*;

  localparam int A_CONV_MAX = 400;

  sac_state_t st_q;
  logic [3:0] pin_s;
  logic cs_s;
  logic above_s;
  logic below_s;
  logic cmp_s;
  logic cs_prev_q;
  logic cs_fall;
  logic start;
  logic step_end;
  logic last_step;
  logic [CNT_W-1:0] lnk_cnt_q;
  logic [CNT_W-1:0] lnk_nxt;
  logic [CNT_W-1:0] lnk_gray_q;
  logic [CNT_W-1:0] cnt_gray_s;
  logic [CNT_W-1:0] cnt_bin_q;
  logic [4:0] step_q;
  logic [3:0] bit_q;
  logic [SAC_BITS-1:0] res_q;
  logic [SAC_BITS-1:0] fifo_rdata;
  logic fifo_wvalid;
  logic fifo_wready;
  logic fifo_rvalid;
  logic fifo_rready;
  logic out_bit;

  sac_sync #(
    .W(4),
    .RST(PIN_RST)
  ) u_pin_sync (
    .i_clk(i_clk_sys),
    .i_resetn(i_resetn),
    .i_d({i_cs_n, i_shutdown_level_input_above, i_shutdown_level_input_below, i_cmp}),
    .o_q(pin_s)
  );

  assign cs_s = pin_s[3];
  assign above_s = pin_s[2];
  assign below_s = pin_s[1];
  assign cmp_s = pin_s[0];
  assign cs_fall = cs_prev_q && !cs_s;
  assign start = (st_q == ST_IDLE) && cs_fall && !below_s;
  assign step_end = (step_q == STEP_LAST);
  assign last_step = step_end && (bit_q == BIT_LSB);

  // Link side: counts serial clock falling edges within one frame.
  // Chip select high clears it, so no edge is needed outside a frame.
  assign lnk_nxt = lnk_cnt_q + CNT_ONE;

  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      lnk_cnt_q <= CNT_EOC;
      lnk_gray_q <= CNT_EOC;
    end else if (lnk_cnt_q != CNT_SAT) begin
      // Saturates so trailing edges never wrap back to data
      lnk_cnt_q <= lnk_nxt; // RULE_14
      lnk_gray_q <= lnk_nxt ^ {1'b0, lnk_nxt[3:1]};
    end
  end

  // Gray code changes one bit per edge, so the word crosses safely
  sac_sync #(
    .W(CNT_W),
    .RST(CNT_EOC)
  ) u_cnt_sync (
    .i_clk(i_clk_sys),
    .i_resetn(i_resetn),
    .i_d(lnk_gray_q),
    .o_q(cnt_gray_s)
  );

  // Binary count one cycle after the gray word lands; the latency is harmless
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_bin_q <= CNT_EOC;
    end else begin
      cnt_bin_q <= sac_gray2bin(cnt_gray_s);
    end
  end

  // Operating mode from the three-level shutdown input
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_shutdown <= 1'b1;
      o_ref_int_en <= 1'b0;
    end else begin
      o_shutdown <= below_s; // RULE_04
      o_ref_int_en <= above_s && !below_s; // RULE_06
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_SHUT;
    end else if (below_s) begin
      st_q <= ST_SHUT; // RULE_17
    end else if (cs_s && (st_q != ST_SHUT)) begin
      // Chip select high aborts or ends any frame
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_SHUT: begin
          st_q <= ST_IDLE; // RULE_05
        end
        ST_IDLE: begin
          if (cs_fall) begin
            st_q <= ST_CONV; // RULE_01
          end
        end
        ST_CONV: begin
          if (last_step) begin
            st_q <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (fifo_wready) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (fifo_rvalid) begin
            st_q <= ST_OUT;
          end
        end
        ST_OUT: begin
          st_q <= ST_OUT;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Successive approximation, one bit per step of STEP_LAST+1 cycles
  // A cut frame leaves the counters mid-way; the next start reloads them
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      step_q <= STEP_ZERO;
      bit_q <= BIT_MSB;
      o_dac_code <= CODE_ZERO;
    end else if (start) begin
      step_q <= STEP_ZERO;
      bit_q <= BIT_MSB;
      o_dac_code <= CODE_MID;
    end else if (st_q == ST_CONV) begin
      step_q <= step_end ? STEP_ZERO : step_q + STEP_ONE; // RULE_12
      if (step_end) begin
        o_dac_code[bit_q] <= cmp_s;
        if (bit_q != BIT_LSB) begin
          o_dac_code[bit_q - BIT_ONE] <= 1'b1;
          bit_q <= bit_q - BIT_ONE;
        end
      end
    end
  end

  // Sample-hold switch
  // Tracking resumes once the last bit is decided, not after read-out,
  // so acquisition overlaps the host's read.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_track <= 1'b0;
    end else if (below_s) begin
      o_track <= 1'b0;
    end else if (st_q == ST_IDLE) begin
      o_track <= !cs_fall; // RULE_08
    end else if (st_q == ST_CONV) begin
      o_track <= cs_s || last_step; // RULE_09
    end else begin
      o_track <= 1'b1;
    end
  end

  // Results queue between the converter and the shift-out register.
  // A full queue holds the sequencer in ST_PUSH rather than drop a result.
  assign fifo_wvalid = (st_q == ST_PUSH);
  // Idle drains results left behind by an aborted frame
  assign fifo_rready = (st_q == ST_LOAD) || (st_q == ST_IDLE);

  sac_fifo #(
    .W(SAC_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_res_fifo (
    .i_clk(i_clk_sys),
    .i_resetn(i_resetn),
    .i_wvalid(fifo_wvalid),
    .o_wready(fifo_wready),
    .i_wdata(o_dac_code),
    .o_rvalid(fifo_rvalid),
    .i_rready(fifo_rready),
    .o_rdata(fifo_rdata)
  );

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      res_q <= CODE_ZERO;
    // Shift-out copy of the head entry, held for the whole read-out
    end else if ((st_q == ST_LOAD) && fifo_rvalid) begin
      res_q <= fifo_rdata;
    end
  end

  // Bit shown for the current falling-edge count
  always_comb begin
    if (cnt_bin_q == CNT_EOC) begin
      out_bit = 1'b1; // RULE_15
    end else if (cnt_bin_q >= CNT_SAT) begin
      out_bit = 1'b0; // RULE_16
    end else begin
      out_bit = res_q[CNT_LAST - cnt_bin_q]; // RULE_07
    end
  end

  // Serial output pin; only the edge count moves it while reading out
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_prev_q <= 1'b1;
      o_dout_oe <= 1'b0;
      o_dout <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      if (cs_s || below_s) begin
        o_dout_oe <= 1'b0; // RULE_02
        o_dout <= 1'b0;
      end else if (start) begin
        o_dout_oe <= 1'b1; // RULE_13
        o_dout <= 1'b0;
      end else if (st_q == ST_OUT) begin
        o_dout <= out_bit; // RULE_03
      end
    end
  end

  // Checks run in the system domain on the synchronised pins
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  a_conv_start: assert property ( // RULE_01
    start |=> (st_q == ST_CONV) && o_dout_oe && !o_dout && !o_track
  ) else $error("Conversion did not start on chip select fall");

  a_hiz_deselect: assert property ( // RULE_02
    cs_s |=> !o_dout_oe
  ) else $error("Serial output driven while deselected");

  a_dout_quiet: assert property ( // RULE_02
    !o_dout_oe |-> !o_dout
  ) else $error("Serial data left high while released");

  a_dout_sclk_only: assert property ( // RULE_03
    (o_dout_oe && $past(o_dout_oe) && ($past(st_q) == ST_OUT)
      && ($past(st_q, 2) == ST_OUT) && $changed(o_dout))
      |-> ($past(cnt_bin_q) != $past(cnt_bin_q, 2))
  ) else $error("Serial output changed without a clock edge");

  a_shutdown_level_input_low: assert property ( // RULE_04
    below_s |=> o_shutdown && !o_ref_int_en && !o_track && (st_q == ST_SHUT)
  ) else $error("Low shutdown input did not shut down");

  a_operate_mode: assert property ( // RULE_05
    !below_s [*2] |=> !o_shutdown && (st_q != ST_SHUT)
  ) else $error("Not operating with shutdown input high or open");

  a_ref_select: assert property ( // RULE_06
    !below_s |=> (o_ref_int_en == $past(above_s))
  ) else $error("Reference selection does not follow shutdown input");

  a_msb_first: assert property ( // RULE_07
    ((st_q == ST_OUT) && (cnt_bin_q == CNT_MSB) && !cs_s && !below_s)
      |=> (o_dout == res_q[BIT_MSB])
  ) else $error("First data bit is not the MSB");

  a_lsb_last: assert property ( // RULE_07
    ((st_q == ST_OUT) && (cnt_bin_q == CNT_LAST) && !cs_s && !below_s)
      |=> (o_dout == res_q[BIT_LSB])
  ) else $error("Twelfth data bit is not the LSB");

  a_hold_freeze: assert property ( // RULE_08
    ((st_q == ST_CONV) && !last_step && !cs_s && !below_s) |=> !o_track
  ) else $error("Sample-hold tracked during conversion");

  a_track_back: assert property ( // RULE_09
    ((st_q == ST_CONV) && last_step && !cs_s && !below_s)
      |=> o_track && (st_q == ST_PUSH)
  ) else $error("Sample-hold not returned to tracking");

  a_conv_bound: assert property ( // RULE_12
    $rose(st_q == ST_CONV) |-> ##[1:A_CONV_MAX] (st_q != ST_CONV)
  ) else $error("Conversion ran too long");

  a_eoc_high: assert property ( // RULE_15
    ((st_q == ST_OUT) && (cnt_bin_q == CNT_EOC) && !cs_s && !below_s)
      |=> o_dout && o_dout_oe
  ) else $error("End of conversion not signalled high");

  a_trail_zero: assert property ( // RULE_16
    ((st_q == ST_OUT) && (cnt_bin_q == CNT_SAT) && !cs_s && !below_s)
      |=> !o_dout && (st_q == ST_OUT)
  ) else $error("Trailing edges did not give zeros");

  c_conv_done: cover property (
    (st_q == ST_CONV) ##1 (st_q == ST_PUSH)
  );

  c_full_read: cover property (
    (st_q == ST_OUT) && (cnt_bin_q == CNT_SAT)
  );

  c_abort: cover property (
    (st_q == ST_CONV) && cs_s
  );

  c_shutdown: cover property (
    (st_q == ST_IDLE) ##1 (st_q == ST_SHUT)
  );

  c_float_conv: cover property (
    (st_q == ST_CONV) && !above_s && !below_s
  );
endmodule : sac_conv_port

// ### test/sac_host.sv
// Serial master model for the conversion port: chip select and serial clock.
// Assumes the bench resolves the data line to Z while the port releases it.
`timescale 1ns/10ps
module sac_host (
  input wire logic i_clk, // System clock, paces chip select
  input wire logic i_dout, // Resolved serial data line
  output logic o_cs_n, // Chip select, active low
  output logic o_sclk // Serial clock, idle low
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
  end

  // 80 cycles high covers both the cs pulse width and the acquisition time
  task automatic start;
    repeat (80) @(negedge i_clk);
    o_cs_n = 1'b0;
  endtask : start

  task automatic stop;
    @(negedge i_clk);
    o_cs_n = 1'b1;
  endtask : stop

  // Samples at the rising edge, long after the previous fall moved the line.
  // One short pulse, then a long low gap keeps the average rate below 2.1 MHz
  task automatic shift(output logic b);
    #7 b = i_dout;
    o_sclk = 1'b1;
    #24 o_sclk = 1'b0;
    #460;
  endtask : shift
endmodule : sac_host

// ### test/sac_conv_port_tb.sv
// Self-checking bench for the conversion port with a host model and an ideal
// comparator. Assumes SAR trials keep a bit while the input is at or above it.
`timescale 1ns/10ps
module sac_conv_port_tb;
  import sac_pkg::*;
  logic i_clk_sys;
  logic i_resetn;
  logic shutdown_level_input_above;
  logic shutdown_level_input_below;
  logic cmp;
  logic dout;
  logic dout_oe;
  logic track;
  logic shutdown;
  logic ref_int_en;
  logic [SAC_BITS-1:0] dac_code;
  logic [SAC_BITS-1:0] analog_input;
  wire logic sclk;
  wire logic cs_n;
  wire logic dout_w;
  int mismatches;
  int total_checks;

  assign dout_w = dout_oe ? dout : 1'bz;

  sac_conv_port dut (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_sclk(sclk),
    .i_cs_n(cs_n),
    .i_shutdown_level_input_above(shutdown_level_input_above),
    .i_shutdown_level_input_below(shutdown_level_input_below),
    .i_cmp(cmp),
    .o_dout(dout),
    .o_dout_oe(dout_oe),
    .o_track(track),
    .o_dac_code(dac_code),
    .o_shutdown(shutdown),
    .o_ref_int_en(ref_int_en)
  );

  sac_host host (
    .i_clk(i_clk_sys),
    .i_dout(dout_w),
    .o_cs_n(cs_n),
    .o_sclk(sclk)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // Ideal comparator on the held sample
  always @(negedge i_clk_sys) begin
    cmp <= (analog_input >= dac_code);
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : settle

  // A full cycle must fit in 9 us, so 450 cycles bound the wait for EOC
  task automatic wait_eoc;
    int n;
    n = 0;
    while (dout_w !== 1'b1 && n < 450) begin
      @(negedge i_clk_sys);
      n++;
    end
    check(n < 450, 1'b1);
    if (n >= 450) begin
      report_and_stop();
    end
  endtask : wait_eoc

  task automatic t_convert(input logic [SAC_BITS-1:0] val);
    logic [15:0] frame;
    logic b;
    analog_input = val;
    host.start();
    settle(5);
    check(dout_w, 1'b0);
    check(track, 1'b0);
    wait_eoc();
    check(track, 1'b1);
    check(dac_code, val);
    settle(20);
    check(dout_w, 1'b1);
    frame = 16'h0000;
    for (int i = 0; i < 13; i++) begin
      host.shift(b);
      frame = {frame[14:0], b};
    end
    check(frame, {3'b000, 1'b1, val});
    for (int i = 0; i < 3; i++) begin
      host.shift(b);
      check(b, 1'b0);
    end
    host.stop();
    settle(6);
    check(dout_w, 1'bz);
  endtask : t_convert

  task automatic t_abort;
    analog_input = 12'h0555;
    host.start();
    settle(60);
    host.stop();
    settle(6);
    check(dout_w, 1'bz);
    check(track, 1'b1);
    t_convert(12'h0ABC);
  endtask : t_abort

  task automatic t_modes;
    logic [1:0] pins [3];
    logic [1:0] exp [3];
    // Floating last, so the conversion below runs on the external reference
    pins = '{2'b01, 2'b10, 2'b00};
    exp = '{2'b10, 2'b01, 2'b00};
    for (int i = 0; i < 3; i++) begin
      shutdown_level_input_above = pins[i][1];
      shutdown_level_input_below = pins[i][0];
      settle(6);
      check({shutdown, ref_int_en}, exp[i]);
    end
    t_convert(12'h0321);
    shutdown_level_input_above = 1'b0;
    shutdown_level_input_below = 1'b1;
    settle(6);
    check({shutdown, ref_int_en}, 2'b10);
    host.start();
    settle(10);
    check(dout_w, 1'bz);
    host.stop();
    shutdown_level_input_above = 1'b1;
    shutdown_level_input_below = 1'b0;
    settle(6);
    check({shutdown, ref_int_en}, 2'b01);
  endtask : t_modes

  initial begin
    mismatches = 0;
    total_checks = 0;
    i_resetn = 1'b0;
    shutdown_level_input_above = 1'b1;
    shutdown_level_input_below = 1'b0;
    analog_input = 12'h0000;
    settle(2);
    i_resetn = 1'b1;
    settle(12);
    t_convert(12'h0A5C);
    t_convert(12'h0FFF);
    t_convert(12'h0000);
    t_convert(12'h0001);
    t_abort();
    t_modes();
    report_and_stop();
  end
endmodule : sac_conv_port_tb
